// File: include/sld_pkg.sv
// Purpose: constants for the strap latch and decode block
// Assumes: strap pins settle before reset release
// Notes:   mode codes are the four-bit strap field values
package sld_pkg;
  localparam int          SLD_ADDR_W       = 5;
  localparam int          SLD_STRAP_ADDR_W = 3;
  localparam int          SLD_MODE_W       = 4;
  localparam logic [1:0]  SLD_ADDR_HI      = 2'h0;
  localparam logic [4:0]  SLD_BCAST_ADDR   = 5'h00;
  localparam logic [4:0]  SLD_ADDR_RST     = 5'h00;
  localparam logic [3:0]  SLD_MODE_RST     = 4'h0;
  // advertisement field order: {1000 full, 1000 half, 10/100 full, 10/100 half}
  localparam logic [3:0]  SLD_ADV_NONE     = 4'h0;
  localparam logic [3:0]  SLD_ADV_FAST     = 4'h3;
  localparam logic [3:0]  SLD_ADV_GIG_FD   = 4'h8;
  localparam logic [3:0]  SLD_ADV_GIG_FAST = 4'hB;
  localparam int          SLD_CLK_MHZ      = 100;

  typedef enum logic [3:0] {
    SLD_MODE_NAND      = 4'h4,
    SLD_MODE_PWRDN     = 4'h7,
    SLD_MODE_RG_FAST1  = 4'h8,
    SLD_MODE_RG_FAST2  = 4'hA,
    SLD_MODE_RG_GIG    = 4'hC,
    SLD_MODE_RG_GIGALL = 4'hE
  } sld_mode_t;

  // life cycle: in reset, one capture cycle, then held
  typedef enum logic [1:0] {
    SLD_ST_RESET = 2'b00,
    SLD_ST_HELD  = 2'b01
  } sld_state_t;
endpackage

// File: logic/sld_strap_latch_decode.sv
// Purpose: latch configuration straps at reset release and decode them
// Assumes: strap inputs synchronous to clk_in; reset_in is the chip reset, active high
// Notes:   all outputs registered; strap values hold until the next reset, address match and recovered select follow their inputs
// Summary of operation
// - capture three address straps once at release
// - pulled up reads 1, down reads 0
// - upper two address bits always zero
// - broadcast strap low: also answer address zero
// - broadcast strap high: own address only
// - enable bit default is inverted broadcast strap
// - mode field latched; reserved codes flagged
// - code 0111 enters power down test
// - 1000 and 1010: reduced pin, 10/100 adverts; 1010 adds interrupt pin
// - 1100: reduced pin, 1000 full only
// - 1110: 1000 full plus 10/100 adverts
// - reference clock strap high drives clock output
// - clock output defaults local, recovered selectable
// - indicator strap 1 individual, 0 tri-color
// - sample straps only at reset release
`timescale 1ns/1ns
`default_nettype none
module sld_strap_latch_decode
  import sld_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  // strap pins
  input  wire logic [sld_pkg::SLD_STRAP_ADDR_W-1:0] mgmt_address_straps_in,
  input  wire logic                          broadcast_address_strap_in,
  input  wire logic [sld_pkg::SLD_MODE_W-1:0] mode_straps_in,
  input  wire logic                          ref_clock_out_strap_in,
  input  wire logic                          indicator_style_strap_in,
  // runtime controls from the management side
  input  wire logic                          recovered_clock_select_in,
  input  wire logic [sld_pkg::SLD_ADDR_W-1:0] access_address_in,
  // decoded configuration
  output logic                               straps_valid_out,
  output logic [sld_pkg::SLD_ADDR_W-1:0]     mgmt_address_out,
  output logic                               broadcast_address_enable_bit_out,
  output logic                               address_match_out,
  output logic [sld_pkg::SLD_MODE_W-1:0]     mode_out,
  output logic                               mode_reserved_out,
  output logic                               nand_tree_mode_out,
  output logic                               power_down_mode_out,
  output logic                               reduced_pin_mac_out,
  output logic [3:0]                         advertise_out,
  output logic                               pin_interrupt_style_out,
  output logic                               ref_clock_out_enable_out,
  output logic                               ref_clock_use_recovered_out,
  output logic                               indicator_individual_out
);
  import sld_pkg::*;

  sld_state_t                   state_q;
  logic [SLD_STRAP_ADDR_W-1:0]  addr_q;
  logic                         bcast_q;
  logic [SLD_MODE_W-1:0]        mode_q;
  logic                         clken_q;
  logic                         style_q;

  // capture happens on the first clock after release only
  wire capture = (state_q == SLD_ST_RESET);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= SLD_ST_RESET;
    end else begin
      state_q <= SLD_ST_HELD;
    end
  end

  // straps are taken by a clocked process after release, never under reset
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      addr_q  <= SLD_ADDR_RST[SLD_STRAP_ADDR_W-1:0];
      bcast_q <= 1'b1;
      mode_q  <= SLD_MODE_RST;
      clken_q <= 1'b0;
      style_q <= 1'b0;
    end else if (capture) begin
      addr_q  <= mgmt_address_straps_in;
      bcast_q <= broadcast_address_strap_in;
      mode_q  <= mode_straps_in;
      clken_q <= ref_clock_out_strap_in;
      style_q <= indicator_style_strap_in;
    end
  end

  // decode from the latched copies
  wire [SLD_ADDR_W-1:0] full_addr = {SLD_ADDR_HI, addr_q};
  wire bcast_en   = ~bcast_q;
  wire hit_own    = (access_address_in == full_addr);
  wire hit_bcast  = bcast_en && (access_address_in == SLD_BCAST_ADDR);
  wire is_nand    = (mode_q == SLD_MODE_NAND);
  wire is_pwrdn   = (mode_q == SLD_MODE_PWRDN);
  wire is_fast1   = (mode_q == SLD_MODE_RG_FAST1);
  wire is_fast2   = (mode_q == SLD_MODE_RG_FAST2);
  wire is_gig     = (mode_q == SLD_MODE_RG_GIG);
  wire is_gigall  = (mode_q == SLD_MODE_RG_GIGALL);
  wire is_rgmii   = is_fast1 | is_fast2 | is_gig | is_gigall;
  wire reserved   = ~(is_rgmii | is_nand | is_pwrdn);
  wire [3:0] adv  = (is_fast1 | is_fast2) ? SLD_ADV_FAST :
                    is_gig                ? SLD_ADV_GIG_FD :
                    is_gigall             ? SLD_ADV_GIG_FAST : SLD_ADV_NONE;
  // recovered clock only meaningful while the output is enabled
  wire use_rec    = clken_q & recovered_clock_select_in;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      straps_valid_out                 <= 1'b0;
      mgmt_address_out                 <= SLD_ADDR_RST;
      broadcast_address_enable_bit_out <= 1'b0;
      address_match_out                <= 1'b0;
      mode_out                         <= SLD_MODE_RST;
      mode_reserved_out                <= 1'b0;
      nand_tree_mode_out               <= 1'b0;
      power_down_mode_out              <= 1'b0;
      reduced_pin_mac_out              <= 1'b0;
      advertise_out                    <= SLD_ADV_NONE;
      pin_interrupt_style_out          <= 1'b0;
      ref_clock_out_enable_out         <= 1'b0;
      ref_clock_use_recovered_out      <= 1'b0;
      indicator_individual_out         <= 1'b0;
    end else begin
      straps_valid_out                 <= ~capture;
      mgmt_address_out                 <= full_addr;
      broadcast_address_enable_bit_out <= bcast_en;
      address_match_out                <= ~capture & (hit_own | hit_bcast);
      mode_out                         <= mode_q;
      mode_reserved_out                <= ~capture & reserved;
      nand_tree_mode_out               <= is_nand;
      power_down_mode_out              <= is_pwrdn;
      reduced_pin_mac_out              <= is_rgmii;
      advertise_out                    <= adv;
      pin_interrupt_style_out          <= is_fast2;
      ref_clock_out_enable_out         <= clken_q;
      ref_clock_use_recovered_out      <= use_rec;
      indicator_individual_out         <= style_q;
    end
  end

  // checks
  sequence release_s;
    $fell(reset_in);
  endsequence

  capture_once_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !capture |=> !capture)
    else $error("straps re-sampled after capture");
  addr_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !capture |=> $stable(addr_q) && $stable(mode_q) && $stable(bcast_q))
    else $error("latched straps changed");
  addr_high_a: assert property (@(posedge clk_in) disable iff (reset_in)
    mgmt_address_out[4:3] == 2'h0)
    else $error("upper address bits not zero");
  addr_capture_a: assert property (@(posedge clk_in) disable iff (reset_in)
    capture |=> ##1 mgmt_address_out[2:0] == $past(mgmt_address_straps_in, 2))
    else $error("address not captured");
  bcast_match_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out && !bcast_q && access_address_in == 5'h00 |=> address_match_out)
    else $error("broadcast address not answered");
  own_only_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out && bcast_q && access_address_in != full_addr |=> !address_match_out)
    else $error("answered foreign address");
  bcast_inv_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out |-> broadcast_address_enable_bit_out == !bcast_q)
    else $error("enable bit not inverted strap");
  gig_adv_a: assert property (@(posedge clk_in) disable iff (reset_in)
    is_gig |=> advertise_out == 4'h8 && reduced_pin_mac_out)
    else $error("1000 full only advertisement wrong");
  fast_adv_a: assert property (@(posedge clk_in) disable iff (reset_in)
    is_fast1 |=> advertise_out == 4'h3 && !pin_interrupt_style_out)
    else $error("10/100 advertisement wrong");
  int_style_a: assert property (@(posedge clk_in) disable iff (reset_in)
    is_fast2 |=> pin_interrupt_style_out && advertise_out == 4'h3)
    else $error("interrupt pin arrangement wrong");
  gigall_adv_a: assert property (@(posedge clk_in) disable iff (reset_in)
    is_gigall |=> advertise_out == 4'hB)
    else $error("combined advertisement wrong");
  test_modes_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (mode_q == 4'h4) |=> nand_tree_mode_out && !power_down_mode_out)
    else $error("nand tree mode not entered");
  pwrdn_mode_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (mode_q == 4'h7) |=> power_down_mode_out && !reduced_pin_mac_out)
    else $error("power down mode not entered");
  clk_en_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out |-> ref_clock_out_enable_out == clken_q)
    else $error("clock output enable mismatch");
  clk_sel_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !clken_q |=> !ref_clock_use_recovered_out)
    else $error("recovered clock chosen while disabled");
  style_a: assert property (@(posedge clk_in) disable iff (reset_in)
    release_s ##1 1'b1 ##1 1'b1 |-> indicator_individual_out == style_q)
    else $error("indicator style mismatch");
  reserved_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out && (mode_q == 4'h0 || mode_q == 4'hF) |=> mode_reserved_out)
    else $error("reserved mode not flagged");
  polarity_a: assert property (@(posedge clk_in) disable iff (reset_in)
    capture && mgmt_address_straps_in == 3'h7 |=> addr_q == 3'h7)
    else $error("pulled-up straps not read as one");
  // once valid, valid and the decoded mode, address and adverts hold until the next reset
  valid_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out |=> straps_valid_out)
    else $error("valid dropped without reset");
  cfg_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out |=> $stable(mode_out) && $stable(mgmt_address_out) && $stable(advertise_out))
    else $error("decoded configuration changed");
  own_match_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out && access_address_in == full_addr |=> address_match_out)
    else $error("own address not answered");
  rec_sel_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out && clken_q && recovered_clock_select_in |=> ref_clock_use_recovered_out)
    else $error("recovered clock not selected");
  no_rsv_a: assert property (@(posedge clk_in) disable iff (reset_in)
    straps_valid_out && !reserved |=> !mode_reserved_out)
    else $error("valid mode flagged reserved");
endmodule
`default_nettype wire

// File: test/sld_strap_board.sv
// Purpose: board side of the strap block: pull resistors and reset source
// Assumes: bench picks the pull pattern and the reset request at falling edges
// Notes:   pins follow the pulls with no delay, so levels settle before release
`timescale 1ns/1ns
`default_nettype none
module sld_strap_board (
  // requests from the bench
  input  wire logic       hold_reset_in,
  input  wire logic [9:0] pulls_in,
  // board nets
  output logic            reset_out,
  output logic [9:0]      straps_out
);
  // pulls are static resistors, so strap levels are never left floating
  assign straps_out = pulls_in;
  assign reset_out  = hold_reset_in;
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Purpose: self-checking bench for the strap latch and decode block
// Assumes: capture on edge 1 after release, outputs valid on edge 2
// Notes:   one row per mode code; other straps derived from the row index
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sld_pkg::*;
  logic       clk_in, rst_req, reset_in, sel, valid, bcen, match, rsv, nand_m, pdn, rpm, intp, cke, rec, ind;
  logic [9:0] pulls, straps;
  logic [4:0] acc, addr;
  logic [3:0] mode, adv;
  logic [8:0] rows [16];
  int         num_errors, n_tests;
  sld_strap_board sld_strap_board_i (.hold_reset_in(rst_req), .pulls_in(pulls), .reset_out(reset_in),
    .straps_out(straps));
  sld_strap_latch_decode sld_strap_latch_decode_i (.clk_in(clk_in), .reset_in(reset_in),
    .mgmt_address_straps_in(straps[2:0]), .mode_straps_in(straps[6:3]), .broadcast_address_strap_in(straps[7]),
    .ref_clock_out_strap_in(straps[8]), .indicator_style_strap_in(straps[9]), .recovered_clock_select_in(sel),
    .access_address_in(acc), .straps_valid_out(valid), .mgmt_address_out(addr),
    .broadcast_address_enable_bit_out(bcen), .address_match_out(match), .mode_out(mode), .mode_reserved_out(rsv),
    .nand_tree_mode_out(nand_m), .power_down_mode_out(pdn), .reduced_pin_mac_out(rpm), .advertise_out(adv),
    .pin_interrupt_style_out(intp), .ref_clock_out_enable_out(cke), .ref_clock_use_recovered_out(rec),
    .indicator_individual_out(ind));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({8'h00, got}, {8'h00, exp});
  endtask
  // pulls: {style, ref clock, broadcast, mode[3:0], address[2:0]}
  task automatic restrap(input logic [9:0] p);
    pulls   = p;
    rst_req = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_req = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    // {reserved, nand, power down, reduced pin, advert[3:0], interrupt style}
    rows = '{9'h100, 9'h100, 9'h100, 9'h100, 9'h080, 9'h100, 9'h100, 9'h040,
             9'h026, 9'h100, 9'h027, 9'h100, 9'h030, 9'h100, 9'h036, 9'h100};
    rst_req = 1'b1;
    pulls = 10'h000;
    sel = 1'b0;
    acc = 5'h00;
    num_errors = 0;
    n_tests = 0;
    repeat (20) @(negedge clk_in);
    chk_bit(valid, 1'b0);
    chk_vec({4'h0, addr}, 9'h000);
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      restrap({i[2], i[1], i[0], i[3:0], i[2:0]});
      chk_vec({rsv, nand_m, pdn, rpm, adv, intp}, rows[i]);
      chk_vec({5'h00, mode}, {5'h00, i[3:0]});
      chk_vec({4'h0, addr}, {6'h00, i[2:0]});
      chk_bit(bcen, ~i[0]);
      chk_bit(cke, i[1]);
      chk_bit(ind, i[2]);
      chk_bit(valid, 1'b1);
    end
    $display("mode table done");
    // straps move right after edge 1 and later: the first capture must stick
    pulls = 10'h245;
    rst_req = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_req = 1'b0;
    @(negedge clk_in);
    chk_bit(valid, 1'b0);
    pulls = 10'h1FA;
    @(negedge clk_in);
    chk_bit(valid, 1'b1);
    repeat (5) @(negedge clk_in);
    chk_vec({4'h0, addr}, 9'h005);
    chk_vec({5'h00, mode}, 9'h008);
    chk_bit(bcen, 1'b1);
    chk_bit(cke, 1'b0);
    chk_bit(ind, 1'b1);
    $display("late strap change done");
    // address answering with broadcast enabled, then disabled
    for (int b = 0; b < 2; b++) begin
      restrap({1'b0, 1'b1, 1'(b), 4'h8, 3'h5});
      acc = 5'h00;
      @(negedge clk_in);
      chk_bit(match, b == 0);
      acc = 5'h05;
      @(negedge clk_in);
      chk_bit(match, 1'b1);
      acc = 5'h03;
      @(negedge clk_in);
      chk_bit(match, 1'b0);
      sel = 1'b1;
      @(negedge clk_in);
      chk_bit(rec, 1'b1);
      sel = 1'b0;
      @(negedge clk_in);
      chk_bit(rec, 1'b0);
    end
    // recovered clock cannot be chosen while the output is off
    restrap(10'h040);
    sel = 1'b1;
    repeat (2) @(negedge clk_in);
    chk_bit(rec, 1'b0);
    $display("address and clock select done");
    complete_run();
  end
endmodule
`default_nettype wire
